/* File: logic/hsa_defines.svh */
// Purpose: named constants of the hue and saturation stage
// Assumes: included by the package and by every design file
// Notes: offsets are byte addresses on the register bus
`ifndef HSA_DEFINES_SVH
`define HSA_DEFINES_SVH

`define HSA_PIXEL_W 8
`define HSA_ADDR_W 8
`define HSA_SECTORS 6
`define HSA_SEL_W 3
`define HSA_LAST_SECTOR 3'h5
`define HSA_HUE_W 8
`define HSA_SAT_W 8
`define HSA_SAT_FRAC 7
`define HSA_HUE_RESET 8'h00
`define HSA_SAT_RESET 8'h80
`define HSA_FRAC_W 8
`define HSA_FRAC_ONE 9'h100
`define HSA_HEX_SPAN 13'h0600
`define HSA_FRAME_W 16

`define HSA_OFF_CTRL 8'h00
`define HSA_OFF_SELECT 8'h04
`define HSA_OFF_HUE 8'h08
`define HSA_OFF_SAT 8'h0C
`define HSA_OFF_STATUS 8'h10
`define HSA_CTRL_ENABLE_BIT 0
`define HSA_CTRL_RESET 1'b1
`define HSA_SELECT_RESET 3'h0

`define HSA_RESP_OKAY 2'h0
`define HSA_RESP_SLVERR 2'h2

`endif

/* File: logic/hsa_pkg.sv */
// Purpose: shared types of the hue and saturation stage
// Assumes: hsa_defines.svh on the include path
// Notes: none
package hsa_pkg;
`include "hsa_defines.svh"

typedef logic [`HSA_HUE_W-1:0] hsa_hue_t;
typedef logic [`HSA_SAT_W-1:0] hsa_sat_t;
typedef logic [`HSA_SEL_W-1:0] hsa_sel_t;
typedef enum logic [1:0] {HSA_W_IDLE, HSA_W_RESP} hsa_wstate_t;
typedef enum logic [1:0] {HSA_R_IDLE, HSA_R_FETCH, HSA_R_RESP} hsa_rstate_t;

endpackage : hsa_pkg

/* File: logic/hsa_sector_if.sv */
// Purpose: carries writes and reads of the per-sector settings
// Assumes: hsa_pkg compiled first
// Notes: three read ports, two for pixels and one for the bus
`timescale 1ns/1ps
`include "hsa_defines.svh"
interface hsa_sector_if import hsa_pkg::*; ();
    logic wrHueEn;
    logic wrSatEn;
    hsa_sel_t wrSel;
    logic [`HSA_HUE_W-1:0] wrValue;
    hsa_sel_t rdSelA;
    hsa_sel_t rdSelB;
    hsa_sel_t rdSelC;
    hsa_hue_t rdHueA;
    hsa_hue_t rdHueB;
    hsa_hue_t rdHueC;
    hsa_sat_t rdSatA;
    hsa_sat_t rdSatB;
    hsa_sat_t rdSatC;
    modport user (output wrHueEn, wrSatEn, wrSel, wrValue, rdSelA, rdSelB, rdSelC,
        input rdHueA, rdHueB, rdHueC, rdSatA, rdSatB, rdSatC);
    modport store (input wrHueEn, wrSatEn, wrSel, wrValue, rdSelA, rdSelB, rdSelC,
        output rdHueA, rdHueB, rdHueC, rdSatA, rdSatB, rdSatC);
endinterface : hsa_sector_if

/* File: logic/hsa_sector_mem.sv */
// Purpose: per-sector hue and saturation store with registered reads
// Assumes: selects below SECTORS
// Notes: every entry resets to neutral
`timescale 1ns/1ps
`include "hsa_defines.svh"
module hsa_sector_mem import hsa_pkg::*; #(
    parameter int SECTORS = `HSA_SECTORS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // settings port
    hsa_sector_if.store port
);
    if (SECTORS < 2 || SECTORS > (1 << `HSA_SEL_W)) begin : g_check
        $error("hsa_sector_mem: SECTORS out of range");
    end

    hsa_hue_t hueMem [SECTORS];
    hsa_sat_t satMem [SECTORS];

    for (genvar i = 0; i < SECTORS; i++) begin : g_entry
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                hueMem[i] <= `HSA_HUE_RESET;
                satMem[i] <= `HSA_SAT_RESET;
            end else begin
                if (port.wrHueEn && port.wrSel == hsa_sel_t'(i)) begin
                    hueMem[i] <= port.wrValue;
                end
                if (port.wrSatEn && port.wrSel == hsa_sel_t'(i)) begin
                    satMem[i] <= port.wrValue;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            port.rdHueA <= `HSA_HUE_RESET;
            port.rdHueB <= `HSA_HUE_RESET;
            port.rdHueC <= `HSA_HUE_RESET;
            port.rdSatA <= `HSA_SAT_RESET;
            port.rdSatB <= `HSA_SAT_RESET;
            port.rdSatC <= `HSA_SAT_RESET;
        end else begin
            port.rdHueA <= hueMem[port.rdSelA];
            port.rdHueB <= hueMem[port.rdSelB];
            port.rdHueC <= hueMem[port.rdSelC];
            port.rdSatA <= satMem[port.rdSelA];
            port.rdSatB <= satMem[port.rdSelB];
            port.rdSatC <= satMem[port.rdSelC];
        end
    end
endmodule : hsa_sector_mem

/* File: logic/hsa_adjust.sv */
// Purpose: per-sector hue rotation and saturation gain on an RGB stream
// Assumes: pixel stream already binned and white balanced upstream
// Notes: fixed latency of FRAC_W+5 cycles, no back-pressure
//
// Summary of operation
// - six sectors R Y G C B M each hold hue and saturation, chosen by selector
// - hue setting is signed, minus one to just under plus one wedge
// - hue zero leaves hue unchanged; resets to zero
// - saturation setting is unsigned, zero to just under two
// - saturation one leaves colourfulness unchanged; resets to one
// - a sector's setting acts on pixels dominated by that sector
// - adjacent hexagon sectors are partly affected by a sector's setting
// - rotation moves towards a neighbour and never past it
// - for red, negative rotates towards yellow, positive towards magenta
// - extreme hue maps the sector fully onto its neighbour colour
// - saturation above one increases colourfulness of dominated pixels
// - saturation zero turns dominated colours into hueless gray
// - adjustment acts on binned pixels, after binning
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "hsa_defines.svh"
module hsa_adjust import hsa_pkg::*; #(
    parameter int PIXEL_W = `HSA_PIXEL_W,
    parameter int ADDR_W = `HSA_ADDR_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register bus write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // register bus read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pixel input
    input wire logic pixInValid,
    input wire logic pixInFrameStart,
    input wire logic pixInLineEnd,
    input wire logic [PIXEL_W-1:0] pixInRed,
    input wire logic [PIXEL_W-1:0] pixInGreen,
    input wire logic [PIXEL_W-1:0] pixInBlue,
    // pixel output
    output logic pixOutValid,
    output logic pixOutFrameStart,
    output logic pixOutLineEnd,
    output logic [PIXEL_W-1:0] pixOutRed,
    output logic [PIXEL_W-1:0] pixOutGreen,
    output logic [PIXEL_W-1:0] pixOutBlue
);
    localparam int DIVN = `HSA_FRAC_W;
    localparam int HW = `HSA_HUE_W;
    localparam int SW = `HSA_SAT_W;
    localparam int POS_W = `HSA_SEL_W + DIVN;
    localparam int SPOS_W = POS_W + 2;

    if (PIXEL_W < 2 || PIXEL_W > 16 || ADDR_W < 5 || ADDR_W > 32) begin : g_check
        $error("hsa_adjust: PIXEL_W or ADDR_W out of range");
    end

    typedef struct packed {
        logic valid;
        logic sof;
        logic eol;
        logic bypass;
        hsa_sel_t wedge;
        logic [PIXEL_W-1:0] red;
        logic [PIXEL_W-1:0] green;
        logic [PIXEL_W-1:0] blue;
        logic [PIXEL_W-1:0] low;
        logic [PIXEL_W-1:0] chroma;
        logic [PIXEL_W:0] rem;
        logic [DIVN-1:0] frac;
    } hsa_stage_t;

    hsa_sector_if sectorBus();

    hsa_sector_mem #(.SECTORS(`HSA_SECTORS)) u_mem (
        .clk(clk),
        .rstn(rstn),
        .port(sectorBus.store)
    );

    ////////////////////////////////////////////////////////////////////////
    // register bus write side
    hsa_wstate_t wState;
    logic awHave;
    logic wHave;
    logic [ADDR_W-1:0] awAddrReg;
    logic [31:0] wDataReg;
    logic [3:0] wStrbReg;
    logic doWrite;
    logic awTake;
    logic wTake;
    logic enableReg;
    hsa_sel_t selectReg;
    logic [ADDR_W-1:0] wOff;

    assign awTake = s_axi_awvalid && s_axi_awready;
    assign wTake = s_axi_wvalid && s_axi_wready;
    assign doWrite = (wState == HSA_W_IDLE) && awHave && wHave;
    assign wOff = {awAddrReg[ADDR_W-1:2], 2'b00};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wState <= HSA_W_IDLE;
            awHave <= 1'b0;
            wHave <= 1'b0;
            awAddrReg <= '0;
            wDataReg <= '0;
            wStrbReg <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `HSA_RESP_OKAY;
        end else begin
            case (wState)
                HSA_W_IDLE: begin
                    if (awTake) begin
                        awAddrReg <= s_axi_awaddr;
                    end
                    if (wTake) begin
                        wDataReg <= s_axi_wdata;
                        wStrbReg <= s_axi_wstrb;
                    end
                    if (doWrite) begin
                        wState <= HSA_W_RESP;
                        awHave <= 1'b0;
                        wHave <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_awready <= 1'b0;
                        s_axi_wready <= 1'b0;
                        case (wOff)
                            `HSA_OFF_CTRL, `HSA_OFF_SELECT, `HSA_OFF_HUE, `HSA_OFF_SAT,
                            `HSA_OFF_STATUS: s_axi_bresp <= `HSA_RESP_OKAY;
                            default: s_axi_bresp <= `HSA_RESP_SLVERR;
                        endcase
                    end else begin
                        awHave <= awHave | awTake;
                        wHave <= wHave | wTake;
                        s_axi_awready <= !(awHave | awTake);
                        s_axi_wready <= !(wHave | wTake);
                    end
                end
                HSA_W_RESP: begin
                    if (s_axi_bready) begin
                        wState <= HSA_W_IDLE;
                        s_axi_bvalid <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready <= 1'b1;
                    end
                end
                default: wState <= HSA_W_IDLE;
            endcase
        end
    end

    // control fields, steered by software
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            enableReg <= `HSA_CTRL_RESET;
            selectReg <= `HSA_SELECT_RESET;
        end else if (doWrite && wStrbReg[0]) begin
            if (wOff == `HSA_OFF_CTRL) begin
                enableReg <= wDataReg[`HSA_CTRL_ENABLE_BIT];
            end
            if (wOff == `HSA_OFF_SELECT && wDataReg[`HSA_SEL_W-1:0] <= `HSA_LAST_SECTOR) begin
                selectReg <= wDataReg[`HSA_SEL_W-1:0];
            end
        end
    end

    assign sectorBus.wrSel = selectReg;
    assign sectorBus.wrValue = wDataReg[HW-1:0];
    assign sectorBus.wrHueEn = doWrite && wStrbReg[0] && wOff == `HSA_OFF_HUE;
    assign sectorBus.wrSatEn = doWrite && wStrbReg[0] && wOff == `HSA_OFF_SAT;
    assign sectorBus.rdSelC = selectReg;

    ////////////////////////////////////////////////////////////////////////
    // register bus read side
    hsa_rstate_t rState;
    logic [ADDR_W-1:0] arAddrReg;
    logic [`HSA_FRAME_W-1:0] frameCountReg;
    logic [ADDR_W-1:0] rOff;

    assign rOff = {arAddrReg[ADDR_W-1:2], 2'b00};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rState <= HSA_R_IDLE;
            arAddrReg <= '0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `HSA_RESP_OKAY;
        end else begin
            case (rState)
                HSA_R_IDLE: begin
                    s_axi_arready <= !(s_axi_arvalid && s_axi_arready);
                    if (s_axi_arvalid && s_axi_arready) begin
                        arAddrReg <= s_axi_araddr;
                        rState <= HSA_R_FETCH;
                    end
                end
                HSA_R_FETCH: begin
                    rState <= HSA_R_RESP;
                    s_axi_rvalid <= 1'b1;
                    s_axi_rresp <= `HSA_RESP_OKAY;
                    case (rOff)
                        `HSA_OFF_CTRL: s_axi_rdata <= 32'(enableReg);
                        `HSA_OFF_SELECT: s_axi_rdata <= 32'(selectReg);
                        `HSA_OFF_HUE: s_axi_rdata <= 32'(sectorBus.rdHueC);
                        `HSA_OFF_SAT: s_axi_rdata <= 32'(sectorBus.rdSatC);
                        `HSA_OFF_STATUS: s_axi_rdata <= 32'(frameCountReg);
                        default: begin
                            s_axi_rdata <= '0;
                            s_axi_rresp <= `HSA_RESP_SLVERR;
                        end
                    endcase
                end
                HSA_R_RESP: begin
                    if (s_axi_rready) begin
                        rState <= HSA_R_IDLE;
                        s_axi_rvalid <= 1'b0;
                        s_axi_arready <= 1'b1;
                    end
                end
                default: rState <= HSA_R_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frameCountReg <= '0;
        end else if (pixInValid && pixInFrameStart) begin
            frameCountReg <= frameCountReg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // classify: hexagon wedge, gray level and chroma
    logic [PIXEL_W-1:0] cHi;
    logic [PIXEL_W-1:0] cLo;
    logic [PIXEL_W-1:0] cNum;
    hsa_sel_t cWedge;
    hsa_stage_t stageIn;
    hsa_stage_t pl [DIVN+1];

    always_comb begin
        if (pixInRed >= pixInGreen && pixInGreen >= pixInBlue) begin
            cWedge = 3'h0; cHi = pixInRed; cLo = pixInBlue; cNum = pixInGreen - pixInBlue;
        end else if (pixInGreen > pixInRed && pixInRed >= pixInBlue) begin
            cWedge = 3'h1; cHi = pixInGreen; cLo = pixInBlue; cNum = pixInGreen - pixInRed;
        end else if (pixInGreen >= pixInBlue && pixInBlue > pixInRed) begin
            cWedge = 3'h2; cHi = pixInGreen; cLo = pixInRed; cNum = pixInBlue - pixInRed;
        end else if (pixInBlue > pixInGreen && pixInGreen > pixInRed) begin
            cWedge = 3'h3; cHi = pixInBlue; cLo = pixInRed; cNum = pixInBlue - pixInGreen;
        end else if (pixInBlue >= pixInRed && pixInRed > pixInGreen) begin
            cWedge = 3'h4; cHi = pixInBlue; cLo = pixInGreen; cNum = pixInRed - pixInGreen;
        end else begin
            cWedge = 3'h5; cHi = pixInRed; cLo = pixInGreen; cNum = pixInRed - pixInBlue;
        end
        // a pixel on a far corner belongs to the next wedge at its start
        if (cNum != '0 && cNum == cHi - cLo) begin
            cNum = '0;
            cWedge = (cWedge == `HSA_LAST_SECTOR) ? 3'h0 : cWedge + 3'h1;
        end
        stageIn = '0;
        stageIn.valid = pixInValid;
        stageIn.sof = pixInFrameStart;
        stageIn.eol = pixInLineEnd;
        stageIn.bypass = !enableReg;
        stageIn.wedge = cWedge;
        stageIn.red = pixInRed;
        stageIn.green = pixInGreen;
        stageIn.blue = pixInBlue;
        stageIn.low = cLo;
        stageIn.chroma = cHi - cLo;
        stageIn.rem = {1'b0, cNum};
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pl[0] <= '0;
        end else begin
            pl[0] <= stageIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // position within the wedge, one quotient bit per stage
    function automatic hsa_stage_t divStep(input hsa_stage_t s);
        hsa_stage_t r;
        logic [PIXEL_W+1:0] twice;
        logic qBit;
        r = s;
        twice = {s.rem, 1'b0};
        qBit = 1'b0;
        if (s.chroma != '0 && twice >= {2'b00, s.chroma}) begin
            twice = twice - {2'b00, s.chroma};
            qBit = 1'b1;
        end
        r.rem = twice[PIXEL_W:0];
        r.frac = {s.frac[DIVN-2:0], qBit};
        return r;
    endfunction : divStep

    for (genvar k = 0; k < DIVN; k++) begin : g_div
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                pl[k+1] <= '0;
            end else begin
                pl[k+1] <= divStep(pl[k]);
            end
        end
    end

    // settings of the wedge's two corner sectors
    assign sectorBus.rdSelA = pl[DIVN].wedge;
    assign sectorBus.rdSelB = (pl[DIVN].wedge == `HSA_LAST_SECTOR) ? 3'h0 : pl[DIVN].wedge + 3'h1;

    ////////////////////////////////////////////////////////////////////////
    // blend corner settings by position, rotate, scale, rebuild
    hsa_stage_t pay9;
    hsa_stage_t st10;
    hsa_stage_t st11;
    logic signed [HW:0] hDiff;
    logic signed [HW+DIVN+1:0] hProd;
    logic signed [HW+DIVN+1:0] hFull;
    logic signed [SW:0] gDiff;
    logic signed [SW+DIVN+1:0] gProd;
    logic signed [SW+DIVN+1:0] gFull;
    logic signed [HW:0] hueEff;
    logic [SW-1:0] gainEff;
    logic signed [SPOS_W-1:0] posS;
    logic [PIXEL_W+SW-1:0] cScaled;
    logic [PIXEL_W:0] cNew;
    logic [PIXEL_W:0] headroom;
    logic [DIVN:0] fr;
    logic [PIXEL_W+DIVN:0] midProd;
    logic [PIXEL_W-1:0] midV;
    logic [PIXEL_W-1:0] hiV;
    logic [PIXEL_W-1:0] oRed;
    logic [PIXEL_W-1:0] oGreen;
    logic [PIXEL_W-1:0] oBlue;

    always_comb begin
        hDiff = $signed({sectorBus.rdHueB[HW-1], sectorBus.rdHueB})
            - $signed({sectorBus.rdHueA[HW-1], sectorBus.rdHueA});
        hProd = hDiff * $signed({1'b0, pay9.frac});
        hFull = $signed({{(DIVN+2){sectorBus.rdHueA[HW-1]}}, sectorBus.rdHueA}) + (hProd >>> DIVN);
        gDiff = $signed({1'b0, sectorBus.rdSatB}) - $signed({1'b0, sectorBus.rdSatA});
        gProd = gDiff * $signed({1'b0, pay9.frac});
        gFull = $signed({{(DIVN+2){1'b0}}, sectorBus.rdSatA}) + (gProd >>> DIVN);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pay9 <= '0;
            st10 <= '0;
            hueEff <= '0;
            gainEff <= `HSA_SAT_RESET;
        end else begin
            pay9 <= pl[DIVN];
            st10 <= pay9;
            // neutral settings keep the exact input values
            st10.bypass <= pay9.bypass
                || (hFull[HW:0] == '0 && gFull[SW-1:0] == `HSA_SAT_RESET);
            hueEff <= hFull[HW:0];
            gainEff <= gFull[SW-1:0];
        end
    end

    always_comb begin
        // a full-scale hue moves one whole wedge, never further
        posS = $signed({2'b00, st10.wedge, st10.frac})
            - $signed({{(SPOS_W-HW-2){hueEff[HW]}}, hueEff, 1'b0});
        if (posS < 0) begin
            posS = posS + $signed(`HSA_HEX_SPAN);
        end else if (posS >= $signed(`HSA_HEX_SPAN)) begin
            posS = posS - $signed(`HSA_HEX_SPAN);
        end
        cScaled = st10.chroma * gainEff;
        cNew = cScaled[PIXEL_W+`HSA_SAT_FRAC:`HSA_SAT_FRAC];
        headroom = {1'b0, ~st10.low};
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st11 <= '0;
        end else begin
            st11 <= st10;
            st11.wedge <= posS[POS_W-1:DIVN];
            st11.frac <= posS[DIVN-1:0];
            st11.chroma <= (cNew > headroom) ? headroom[PIXEL_W-1:0] : cNew[PIXEL_W-1:0];
        end
    end

    always_comb begin
        fr = st11.wedge[0] ? (`HSA_FRAC_ONE - {1'b0, st11.frac}) : {1'b0, st11.frac};
        midProd = st11.chroma * fr;
        midV = st11.low + midProd[PIXEL_W+DIVN-1:DIVN];
        hiV = st11.low + st11.chroma;
        case (st11.wedge)
            3'h0: begin oRed = hiV; oGreen = midV; oBlue = st11.low; end
            3'h1: begin oRed = midV; oGreen = hiV; oBlue = st11.low; end
            3'h2: begin oRed = st11.low; oGreen = hiV; oBlue = midV; end
            3'h3: begin oRed = st11.low; oGreen = midV; oBlue = hiV; end
            3'h4: begin oRed = midV; oGreen = st11.low; oBlue = hiV; end
            3'h5: begin oRed = hiV; oGreen = st11.low; oBlue = midV; end
            default: begin oRed = st11.red; oGreen = st11.green; oBlue = st11.blue; end
        endcase
        if (st11.bypass || (st11.red == st11.green && st11.green == st11.blue)) begin
            oRed = st11.red;
            oGreen = st11.green;
            oBlue = st11.blue;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pixOutValid <= 1'b0;
            pixOutFrameStart <= 1'b0;
            pixOutLineEnd <= 1'b0;
            pixOutRed <= '0;
            pixOutGreen <= '0;
            pixOutBlue <= '0;
        end else begin
            pixOutValid <= st11.valid;
            pixOutFrameStart <= st11.sof;
            pixOutLineEnd <= st11.eol;
            pixOutRed <= oRed;
            pixOutGreen <= oGreen;
            pixOutBlue <= oBlue;
        end
    end
endmodule : hsa_adjust

/* File: verification/hsa_adjust_assertions.sv */
// Purpose: port checks of hsa_adjust
// Assumes: bound from the bench top
// Notes: none
`timescale 1ns/1ps
module hsa_adjust_assertions #(parameter int PIXEL_W = 8) (
    // bus
    input wire logic clk, rstn, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic s_axi_bvalid, s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_bresp,
    // pixels
    input wire logic pixInValid, pixInFrameStart, pixOutValid, pixOutFrameStart,
    input wire logic [PIXEL_W-1:0] pixInRed, pixInGreen, pixInBlue, pixOutRed, pixOutBlue
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
        else $error("late read");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read dropped");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_pix_latency: assert property (pixInValid |-> ##13 pixOutValid)
        else $error("pixel lost");
    a_idle_latency: assert property (!pixInValid |-> ##13 !pixOutValid)
        else $error("extra pixel");
    a_frame_kept: assert property (pixInValid && pixInFrameStart |-> ##13 pixOutFrameStart)
        else $error("frame start lost");
    a_frame_clear: assert property (pixInValid && !pixInFrameStart |-> ##13 !pixOutFrameStart)
        else $error("extra frame start");
    a_gray_pass: assert property (pixInValid && pixInRed == pixInGreen && pixInGreen == pixInBlue |-> ##13
        pixOutRed == $past(pixInRed, 13) && pixOutBlue == $past(pixInBlue, 13))
        else $error("gray changed");
endmodule : hsa_adjust_assertions

/* File: verification/hsa_pixel_source.sv */
// Purpose: upstream pixel pipeline model
// Assumes: pixels already binned and white balanced
// Notes: idle data lines show the inverse of the last pixel
`timescale 1ns/1ps
module hsa_pixel_source #(parameter int PIXEL_W = 8) (
    // stream
    input wire logic clk,
    output logic valid, frameStart, lineEnd,
    output logic [PIXEL_W-1:0] red, green, blue
);
    initial {valid, frameStart, lineEnd, red, green, blue} = '0;
    // one pixel per call, balanced before it reaches the block
    task automatic send(input logic [3*PIXEL_W-1:0] rgb, input logic [1:0] mark);
        @(posedge clk);
        valid <= 1'h1;
        {frameStart, lineEnd} <= mark;
        {red, green, blue} <= rgb;
    endtask : send
    task automatic idle();
        @(posedge clk);
        {valid, frameStart, lineEnd} <= 3'h0;
        {red, green, blue} <= ~{red, green, blue};
    endtask : idle
endmodule : hsa_pixel_source

/* File: verification/hsa_adjust_tb.sv */
// Purpose: register and pixel tests of hsa_adjust
// Assumes: output side always accepts
// Notes: none
`timescale 1ns/1ps
`include "hsa_defines.svh"
module hsa_adjust_tb;
    logic clk = 1'h0, rstn = 1'h0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, pixInRed, pixInGreen, pixInBlue;
    logic [7:0] pixOutRed, pixOutGreen, pixOutBlue;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pixInValid, pixOutValid;
    logic pixInFrameStart, pixInLineEnd, pixOutFrameStart, pixOutLineEnd;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int num_errors = 0, check_count = 0, cycles = 0;
    always #25 clk = ~clk;
    hsa_adjust dut (.*);
    hsa_pixel_source src (.clk, .valid(pixInValid), .frameStart(pixInFrameStart), .lineEnd(pixInLineEnd),
        .red(pixInRed), .green(pixInGreen), .blue(pixInBlue));
    always @(posedge clk) if (++cycles == 3000) begin
        num_errors++;
        tally_and_finish();
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
        do begin
            @(posedge clk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (!(w ? s_axi_bvalid === 1'h1 : s_axi_rvalid === 1'h1));
        {s_axi_bready, s_axi_rready} <= 2'h0;
        chk("resp", 32'(r), 32'(w ? s_axi_bresp : s_axi_rresp));
        if (!w) chk("rdata", d, s_axi_rdata);
    endtask : acc
    task automatic px(input logic [23:0] d, e);
        src.send(d, {d[2], d[3]});
        src.idle();
        for (int i = 0; i < 30 && pixOutValid !== 1'h1; i++) @(posedge clk);
        chk("pixel", 32'({1'h1, d[2], d[3], e}),
            32'({pixOutValid, pixOutFrameStart, pixOutLineEnd, pixOutRed, pixOutGreen, pixOutBlue}));
    endtask : px
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'h1;
        for (int s = 0; s < 6; s++) begin
            acc(1'h1, `HSA_OFF_SELECT, 32'(s), 2'h0);
            acc(1'h0, `HSA_OFF_HUE, 32'h0, 2'h0);
            acc(1'h0, `HSA_OFF_SAT, 32'h80, 2'h0);
        end
        $display("test reset_values done");
        acc(1'h1, `HSA_OFF_HUE, 32'h80, 2'h0);
        acc(1'h0, `HSA_OFF_HUE, 32'h80, 2'h0);
        acc(1'h1, `HSA_OFF_SAT, 32'hFF, 2'h0);
        acc(1'h0, `HSA_OFF_SAT, 32'hFF, 2'h0);
        acc(1'h1, `HSA_OFF_SELECT, 32'h6, 2'h0);
        acc(1'h0, `HSA_OFF_SELECT, 32'h5, 2'h0);
        acc(1'h0, 8'h20, 32'h0, 2'h2);
        $display("test setting_ranges done");
        acc(1'h1, `HSA_OFF_SELECT, 32'h0, 2'h0);
        acc(1'h1, `HSA_OFF_HUE, 32'h80, 2'h0);
        acc(1'h1, `HSA_OFF_SELECT, 32'h2, 2'h0);
        acc(1'h1, `HSA_OFF_SAT, 32'h0, 2'h0);
        px(24'hFF0000, 24'hFFFF00);
        px(24'h00C800, 24'h000000);
        px(24'h646464, 24'h646464);
        px(24'h3264C8, 24'h3264C8);
        px(24'hFF8000, 24'hFFFF00);
        px(24'h400040, 24'h7F0000);
        acc(1'h0, `HSA_OFF_STATUS, 32'h1, 2'h0);
        $display("test pixel_adjust done");
        acc(1'h1, `HSA_OFF_CTRL, 32'h0, 2'h0);
        acc(1'h0, `HSA_OFF_CTRL, 32'h0, 2'h0);
        px(24'hFF0000, 24'hFF0000);
        $display("test adjust_off done");
        tally_and_finish();
    end
endmodule : hsa_adjust_tb
bind hsa_adjust hsa_adjust_assertions #(.PIXEL_W(PIXEL_W)) chk (.*);
